/* File: core/cet_pkg.sv */
// package of the execution timing and memory configuration block
// assumes one core clock and zero wait state operand memory
package cet_pkg;
  // operand size codes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } cet_size_e;
  // effective address modes
  typedef enum logic [3:0] {
    EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3,
    EA_PREDEC = 4'h4, EA_DISP16 = 4'h5, EA_INDEX = 4'h6, EA_ABS_W = 4'h7,
    EA_ABS_L = 4'h8, EA_PC_DISP = 4'h9, EA_PC_INDEX = 4'hA, EA_IMM = 4'hB
  } cet_mode_e;
  // instruction classes
  typedef enum logic [1:0] {
    OP_MOVE = 2'b00,
    OP_RMW = 2'b01,
    OP_MULTI_MOVE = 2'b10
  } cet_op_e;
  // one decoded instruction
  typedef struct packed {
    cet_op_e op;
    cet_size_e size;
    cet_mode_e src;
    cet_mode_e dst;
    logic [1:0] src_addr_lo;
    logic [1:0] dst_addr_lo;
  } cet_instr_s;
  // timing entry c(r/w)
  typedef struct packed {
    logic [3:0] cycles;
    logic [1:0] reads;
    logic [1:0] writes;
  } cet_time_s;
  // store resource busy window in cycles
  localparam logic [1:0] STORE_BUSY_CYC = 2'h2;
  // config word field positions
  localparam int FLASH_LSB = 20;
  localparam int SRAM_LSB = 4;
  // size codes reported by this device
  localparam logic [3:0] FLASH_CODE = 4'h8;
  localparam logic [3:0] SRAM_CODE = 4'h5;
  localparam logic [3:0] FLASH_MIN_CODE = 4'h8;
  localparam logic [3:0] FLASH_MAX_CODE = 4'hB;
  localparam logic [3:0] SRAM_MAX_CODE = 4'h9;
  // reset value of the word before the post reset load
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // word loaded after reset, reserved ranges zero
  localparam logic [31:0] CFG_LOAD_WORD =
    (32'(FLASH_CODE) << FLASH_LSB) | (32'(SRAM_CODE) << SRAM_LSB);
endpackage

/* File: core/cet_core.sv */
// operand timing calculator, store stall control and memory config word
// assumes instruction requests come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module cet_core (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire cet_pkg::cet_instr_s INSTR_I,
  output logic INSTR_READY_O,
  output logic TIME_VALID_O,
  output cet_pkg::cet_time_s TIME_O,
  input wire logic CFG_WR_I,
  input wire logic [31:0] CFG_WDATA_I,
  output logic [31:0] CFG_WORD_O,
  output logic CFG_LOAD_O,
  output logic [9:0] FLASH_KB_O,
  output logic [17:0] SRAM_BYTES_O,
  output logic CFG_RSVD_O
);
  import cet_pkg::*;

  // instruction port: a request is taken on an edge where valid and
  // ready are both high; the timing answer follows on the next edge
  // and stands until the next answer, with its valid for one cycle
  // only. ready drops for a store inside the busy window, so the
  // requester must hold the instruction steady until it is taken.
  // the config word is written by the core a cycle after the strobe;
  // the decoded sizes follow it without a register stage.

  ////////////////////////////////////////////////////////////////////
  // helper functions
  // pure decoders shared by the timing path and the config word;
  // kept as functions so both operands use one definition

  // memory operand test, used for both source and destination
  function automatic logic is_mem(input cet_mode_e m);
    is_mem = !(m == EA_DREG || m == EA_AREG || m == EA_IMM);
  endfunction

  // fold pc relative and long absolute onto their twins
  function automatic cet_mode_e norm(input cet_mode_e m);
    norm = m;
    if (m == EA_PC_DISP) begin
      norm = EA_DISP16;
    end else if (m == EA_PC_INDEX) begin
      norm = EA_INDEX;
    end else if (m == EA_ABS_L) begin
      norm = EA_ABS_W;
    end
  endfunction

  // move timing table, modes already folded
  function automatic cet_time_s move_time(input cet_size_e sz, input cet_mode_e s,
                                         input cet_mode_e d);
    cet_time_s t;
    logic smem;
    logic dmem;
    logic six;
    logic dix;
    smem = is_mem(s);
    dmem = is_mem(d);
    six = (s == EA_INDEX);
    dix = (d == EA_INDEX);
    // default is the register to register entry
    t = '{cycles: 4'h1, reads: 2'h0, writes: 2'h0};
    if (s == EA_IMM) begin
      // immediate source, nothing read
      if (dmem) begin
        t.writes = 2'h1;
        t.cycles = (sz == SZ_LONG) ? 4'h2 : 4'h3;
      end
    end else if (!smem) begin
      // register source
      if (dmem) begin
        t.writes = 2'h1;
        t.cycles = dix ? 4'h2 : 4'h1;
      end
    end else begin
      // memory source, one read
      t.reads = 2'h1;
      t.writes = dmem ? 2'h1 : 2'h0;
      if (sz == SZ_LONG) begin
        t.cycles = (six || dix) ? 4'h3 : 4'h2;
      end else if (!dmem) begin
        t.cycles = six ? 4'h3 : 4'h2;
      end else begin
        t.cycles = (six || dix) ? 4'h4 : 4'h3;
      end
    end
    move_time = t;
  endfunction

  // extra cost of a misaligned operand access
  function automatic cet_time_s split_cost(input cet_size_e sz, input logic [1:0] lo,
                                          input logic wr);
    cet_time_s t;
    logic odd;
    odd = lo[0];
    t = '{cycles: 4'h0, reads: 2'h0, writes: 2'h0};
    if ((sz == SZ_LONG) && odd) begin
      // byte, word, byte
      t.cycles = wr ? 4'h2 : 4'h3;
      t.reads = wr ? 2'h0 : 2'h2;
      t.writes = wr ? 2'h2 : 2'h0;
    end else if (((sz == SZ_WORD) && odd) || ((sz == SZ_LONG) && (lo == 2'b10))) begin
      // two halves
      t.cycles = wr ? 4'h1 : 4'h2;
      t.reads = wr ? 2'h0 : 2'h1;
      t.writes = wr ? 2'h1 : 2'h0;
    end
    split_cost = t;
  endfunction

  // flash size code to kilobytes, zero for none or reserved
  function automatic logic [9:0] flash_kb(input logic [3:0] c);
    flash_kb = 10'h000;
    if (c >= FLASH_MIN_CODE && c <= FLASH_MAX_CODE) begin
      flash_kb = 10'(10'h040 << (c - FLASH_MIN_CODE));
    end
  endfunction

  // sram size code to bytes, doubling from 512
  function automatic logic [17:0] sram_bytes(input logic [3:0] c);
    sram_bytes = 18'h00000;
    if (c != 4'h0 && c <= SRAM_MAX_CODE) begin
      sram_bytes = 18'(18'h00200 << (c - 4'h1));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // timing decode
  // all of this is combinational from the request; the registered
  // answer stage below is the only pipeline step, which keeps the
  // answer one cycle behind acceptance regardless of the entry

  // folded addressing modes
  wire cet_mode_e src_n = norm(INSTR_I.src);
  wire cet_mode_e dst_n = norm(INSTR_I.dst);
  // memory operand flags
  wire logic src_mem = is_mem(src_n);
  wire logic dst_mem = is_mem(dst_n);
  // base entry for a move
  wire cet_time_s mv_t = move_time(INSTR_I.size, src_n, dst_n);
  // base entry for a read modify write on the destination
  cet_time_s rmw_t;
  // split penalties, read side and write side
  cet_time_s rd_pen;
  cet_time_s wr_pen;
  // base entry chosen by class
  cet_time_s base_t;
  // full entry for this instruction
  cet_time_s next_time;

  // read modify write: memory destination reads once, writes once
  always_comb begin
    rmw_t = '{cycles: 4'h1, reads: 2'h0, writes: 2'h0};
    if (dst_mem) begin
      rmw_t.cycles = (dst_n == EA_INDEX) ? 4'h4 : 4'h3;
      rmw_t.reads = 2'h1;
      rmw_t.writes = 2'h1;
    end
  end

  // the read of an rmw uses the destination address
  wire logic rd_used = (INSTR_I.op == OP_MOVE) ? src_mem : dst_mem;
  wire logic [1:0] rd_lo = (INSTR_I.op == OP_MOVE) ? INSTR_I.src_addr_lo
                                                    : INSTR_I.dst_addr_lo;

  // misalignment penalties only where an operand access exists
  always_comb begin
    rd_pen = '{cycles: 4'h0, reads: 2'h0, writes: 2'h0};
    wr_pen = '{cycles: 4'h0, reads: 2'h0, writes: 2'h0};
    if (INSTR_I.op != OP_MULTI_MOVE) begin
      if (rd_used) begin
        rd_pen = split_cost(INSTR_I.size, rd_lo, 1'b0);
      end
      if (dst_mem) begin
        wr_pen = split_cost(INSTR_I.size, INSTR_I.dst_addr_lo, 1'b1);
      end
    end
  end

  // multi register move timing lies outside this table: reported as zero
  always_comb begin
    unique case (INSTR_I.op)
      OP_MOVE: base_t = mv_t;
      OP_RMW: base_t = rmw_t;
      default: base_t = '{cycles: 4'h0, reads: 2'h0, writes: 2'h0};
    endcase
  end

  // total in core cycles, including every operand access; widths
  // hold the worst case of 9 cycles, 3 reads, 3 writes
  always_comb begin
    next_time.cycles = 4'(base_t.cycles + rd_pen.cycles + wr_pen.cycles);
    next_time.reads = 2'(base_t.reads + rd_pen.reads);
    next_time.writes = 2'(base_t.writes + wr_pen.writes);
  end

  ////////////////////////////////////////////////////////////////////
  // store stall control
  // the store test uses the full total, so a write created only by a
  // misaligned split still counts as a store; multi register moves
  // run on separate resources and never open or wait on the window

  // cycles left in the store busy window
  logic [1:0] busy_cnt;
  // this request writes memory and uses the store resources
  wire logic is_store = (next_time.writes != 2'h0) && (INSTR_I.op != OP_MULTI_MOVE);
  // a store waits while the window is open; others pass freely
  wire logic stall = is_store && (busy_cnt != 2'h0);
  // request taken this cycle
  wire logic accept = INSTR_VALID_I && !stall;

  // ready is combinational so a waiting store is released on the edge
  // the window closes, with no extra cycle of latency
  assign INSTR_READY_O = !stall;

  // window opens after the accepted store, counts down to zero, so
  // a waiting store never stalls more than the window length
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt <= 2'h0;
    end else if (accept && is_store) begin
      busy_cnt <= STORE_BUSY_CYC;
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
    end
  end

  // registered timing answer, one cycle after acceptance
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TIME_VALID_O <= 1'b0;
      TIME_O <= '0;
    end else begin
      TIME_VALID_O <= accept;
      if (accept) begin
        TIME_O <= next_time; // figures assume no memory wait
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // memory configuration word
  // the word lives here as general register one; reserved ranges load
  // as zero but a later core write may set them, and the reserved
  // flag below only watches the two size fields

  // set once the post reset load has happened
  // reset clears it, so every release of reset reloads the word
  logic cfg_loaded;

  // first edge after reset release loads the word; the load wins over
  // a core write in that same cycle, so the debugger sees the real word
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_loaded <= 1'b0;
      CFG_LOAD_O <= 1'b0;
      CFG_WORD_O <= CFG_RESET;
    end else begin
      cfg_loaded <= 1'b1;
      CFG_LOAD_O <= !cfg_loaded;
      if (!cfg_loaded) begin
        CFG_WORD_O <= CFG_LOAD_WORD;
      end else if (CFG_WR_I) begin
        CFG_WORD_O <= CFG_WDATA_I;
      end
    end
  end

  // size fields of the current word
  wire logic [3:0] flash_code = CFG_WORD_O[FLASH_LSB +: 4];
  wire logic [3:0] sram_code = CFG_WORD_O[SRAM_LSB +: 4];

  // decoded sizes follow the register directly
  assign FLASH_KB_O = flash_kb(flash_code);
  assign SRAM_BYTES_O = sram_bytes(sram_code);
  // flag reserved codes in either field
  assign CFG_RSVD_O = (flash_code > FLASH_MAX_CODE) || (sram_code > SRAM_MAX_CODE);

  // limitation: the timing figures hold only for zero wait operand
  // memory; a slower memory stretches real execution beyond them
endmodule

`default_nettype wire

/* File: sim/cet_core_asserts.sv */
// port checker of the execution timing block
// assumes binding onto cet_core with one clock and async low reset
`timescale 1ns/1ns
`default_nettype none
module cet_core_asserts
  import cet_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire cet_pkg::cet_instr_s INSTR_I,
  input wire logic INSTR_READY_O,
  input wire logic TIME_VALID_O,
  input wire cet_pkg::cet_time_s TIME_O,
  input wire logic [31:0] CFG_WORD_O,
  input wire logic CFG_LOAD_O,
  input wire logic [9:0] FLASH_KB_O,
  input wire logic [17:0] SRAM_BYTES_O,
  input wire logic CFG_RSVD_O
);
  import cet_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // request taken this edge
  wire logic take = INSTR_VALID_I && INSTR_READY_O;
  // a store writes memory; a register target never does
  wire logic st = INSTR_I.op != OP_MULTI_MOVE && !(INSTR_I.dst inside {EA_DREG, EA_AREG});
  wire logic [3:0] fc = CFG_WORD_O[23:20];
  wire logic [3:0] sc = CFG_WORD_O[7:4];
  ////////////////////////////////////////////////////////////////
  answer_next_a: assert property (take |=> TIME_VALID_O) else $error("no answer");
  valid_pulse_a: assert property (!take |=> !TIME_VALID_O)
    else $error("answer without request");
  time_hold_a: assert property (!TIME_VALID_O |-> $stable(TIME_O))
    else $error("time moved");
  // ready only means something while a request is offered; the idle
  // requester shows a scrambled instruction that may not be a store
  store_busy_a: assert property (take && st |=>
    (!INSTR_VALID_I || !st || !INSTR_READY_O) [*2]) else $error("store not stalled");
  stall_max_a: assert property (take && st |=> ##2 INSTR_READY_O)
    else $error("long stall");
  free_pass_a: assert property (!st |-> INSTR_READY_O) else $error("non store held");
  cfg_load_a: assert property (CFG_LOAD_O |-> CFG_WORD_O == CFG_LOAD_WORD ##1 !CFG_LOAD_O)
    else $error("bad load");
  rsvd_zero_a: assert property (CFG_LOAD_O |-> (CFG_WORD_O & 32'hFF0F_FF0F) == '0)
    else $error("reserved bits set");
  sram_code_a: assert property (CFG_LOAD_O |-> sc == 4'h5) else $error("sram code");
  flash_dec_a: assert property (FLASH_KB_O ==
    (fc[3:2] == 2'h2 ? 10'h040 << fc[1:0] : 10'h000)) else $error("flash decode");
  sram_dec_a: assert property (SRAM_BYTES_O ==
    (sc inside {[4'h1:4'h9]} ? 18'h00100 << sc : 18'h0)) else $error("sram decode");
  rsvd_flag_a: assert property (CFG_RSVD_O == (fc > 4'hB || sc > 4'h9))
    else $error("rsvd flag");
  cover property (take && st);
  cover property (INSTR_VALID_I && !INSTR_READY_O);
  cover property (CFG_LOAD_O);
endmodule
bind cet_core cet_core_asserts cet_core_asserts_i (.CLK_I, .RST_N_I, .INSTR_VALID_I, .INSTR_I,
  .INSTR_READY_O, .TIME_VALID_O, .TIME_O, .CFG_WORD_O, .CFG_LOAD_O, .FLASH_KB_O, .SRAM_BYTES_O,
  .CFG_RSVD_O);
`default_nettype wire

/* File: sim/cet_req_model.sv */
// requester standing at the far side of the instruction port
// assumes go_i and instr_i change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module cet_req_model
  import cet_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire cet_pkg::cet_instr_s instr_i,
  input wire logic ready_i,
  output logic valid_o,
  output cet_pkg::cet_instr_s instr_o
);
  import cet_pkg::*;
  initial begin
    valid_o = 1'b0;
    instr_o = '0;
  end
  // hold the request until taken; operand memory never waits
  always @(posedge clk_i) begin
    if (go_i) begin
      valid_o <= 1'b1;
      instr_o <= instr_i;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      // stale request must not look valid, so invert it
      instr_o <= ~instr_o;
    end
  end
endmodule
`default_nettype wire

/* File: sim/cet_core_tb.sv */
// self-checking bench of the execution timing block
// assumes cet_core, the checker and the requester model are compiled first
`timescale 1ns/1ns
`default_nettype none
module cet_core_tb;
  import cet_pkg::*;
  logic clk, rst_n, go, vld, rdy, tv, cwr, cld, crs;
  cet_instr_s din, ins;
  cet_time_s tim;
  logic [31:0] cwd, cwo, d;
  logic [9:0] fkb;
  logic [17:0] sb;
  int n_errors, n_tests, seed, k;
  cet_req_model cet_req_model_i (.clk_i(clk), .go_i(go), .instr_i(din), .ready_i(rdy),
    .valid_o(vld), .instr_o(ins));
  cet_core cet_core_i (.CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(vld), .INSTR_I(ins),
    .INSTR_READY_O(rdy), .TIME_VALID_O(tv), .TIME_O(tim), .CFG_WR_I(cwr), .CFG_WDATA_I(cwd),
    .CFG_WORD_O(cwo), .CFG_LOAD_O(cld), .FLASH_KB_O(fkb), .SRAM_BYTES_O(sb), .CFG_RSVD_O(crs));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // mode class: 0 register, 1 plain memory, 2 indexed, 3 immediate
  function automatic int cls(cet_mode_e m);
    case (m)
      EA_DREG, EA_AREG: return 0;
      EA_INDEX, EA_PC_INDEX: return 2;
      EA_IMM: return 3;
      default: return 1;
    endcase
  endfunction
  // extra pieces of a misaligned operand
  function automatic int mis(cet_size_e s, logic [1:0] lo);
    if (s == SZ_WORD) return lo[0];
    if (s == SZ_LONG) return lo[0] ? 2 : lo[1];
    return 0;
  endfunction
  function automatic cet_time_s exp_t(cet_instr_s i);
    int c, r, w, sc, dc, m;
    sc = cls(i.src);
    dc = cls(i.dst);
    if (i.op == OP_MULTI_MOVE) return 8'h00;
    if (i.op == OP_RMW) begin
      r = dc != 0;
      w = r;
      c = dc == 0 ? 1 : 2 + dc;
      m = r ? mis(i.size, i.dst_addr_lo) : 0;
    end else begin
      r = sc == 1 || sc == 2;
      w = dc != 0;
      c = r ? 2 + (sc == 2) + (dc == 2) + (w && i.size != SZ_LONG)
            : 1 + (sc == 3 ? w : dc == 2);
      m = r ? mis(i.size, i.src_addr_lo) : 0;
    end
    c += m ? m + 1 : 0;
    r += m;
    m = w ? mis(i.size, i.dst_addr_lo) : 0;
    c += m;
    w += m;
    return {4'(c), 2'(r), 2'(w)};
  endfunction
  function automatic cet_instr_s rnd();
    logic [31:0] v;
    cet_instr_s i;
    v = $random(seed);
    i.op = cet_op_e'(v[1:0] == 2'h3 ? 2'h0 : v[1:0]);
    i.size = cet_size_e'(v[3:2] == 2'h3 ? 2'h2 : v[3:2]);
    i.src = cet_mode_e'(v[7:4] % 4'hC);
    i.dst = cet_mode_e'(v[11:8] % 4'hB);
    i.src_addr_lo = v[13:12];
    i.dst_addr_lo = v[15:14];
    // combinations without a timing entry are steered away
    if (cls(i.src) > 1 && cls(i.dst) == 2) i.dst = EA_IND;
    if (cls(i.src) == 3 && cls(i.dst) > 0) i.size = SZ_LONG;
    return i;
  endfunction
  ////////////////////////////////////////////////////////////////
  // two requests on consecutive cycles, the second inside the busy window when the first is a store
  task automatic pair(cet_instr_s a, cet_instr_s b);
    cet_time_s ea, eb;
    ea = exp_t(a);
    eb = exp_t(b);
    go = 1'b1;
    din = a;
    @(negedge clk);
    din = b;
    @(negedge clk);
    go = 1'b0;
    chk("answer a", tv, 1);
    chk("time a", tim, ea);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tv !== 1'b1 && k < 8);
    chk("latency b", k, ea.writes != 0 && eb.writes != 0 ? 3 : 1);
    chk("time b", tim, eb);
    repeat (2) @(negedge clk);
  endtask
  task automatic cfg(logic [31:0] w);
    cwr = 1'b1;
    cwd = w;
    @(negedge clk);
    // strobe stays up between calls; the caller lowers it after the last
    chk("cfg word", cwo, w);
    chk("flash kb", fkb, w[23:20] inside {[4'h8:4'hB]} ? 32'h40 << w[21:20] : 0);
    chk("sram bytes", sb, w[7:4] inside {[4'h1:4'h9]} ? 32'h100 << w[7:4] : 0);
    chk("rsvd flag", crs, w[23:20] > 4'hB || w[7:4] > 4'h9);
  endtask
  initial begin
    seed = 28;
    rst_n = 1'b0;
    go = 1'b0;
    cwr = 1'b0;
    cwd = '0;
    din = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("load pulse", cld, 1);
    chk("load word", cwo, {8'h00, FLASH_CODE, 12'h000, 4'h5, 4'h0});
    chk("sram at load", sb, 32'h2000);
    for (int c = 0; c < 16; c++) begin
      d = $random(seed);
      d[23:20] = 4'(c);
      d[7:4] = 4'(15 - c);
      cfg(d);
    end
    cwr = 1'b0;
    pair('{OP_MOVE, SZ_LONG, EA_DREG, EA_IND, 2'h0, 2'h0},
         '{OP_MOVE, SZ_WORD, EA_DREG, EA_DISP16, 2'h0, 2'h1});
    pair('{OP_MOVE, SZ_LONG, EA_IND, EA_PREDEC, 2'h3, 2'h0},
         '{OP_MULTI_MOVE, SZ_LONG, EA_DREG, EA_IND, 2'h0, 2'h0});
    pair('{OP_RMW, SZ_LONG, EA_DREG, EA_INDEX, 2'h0, 2'h2},
         '{OP_MOVE, SZ_LONG, EA_IMM, EA_ABS_L, 2'h0, 2'h1});
    repeat (150) pair(rnd(), rnd());
    // second reset in mid-run reloads the word; a write held across the
    // release must lose to the load
    rst_n = 1'b0;
    cwr = 1'b1;
    cwd = 32'hFFFF_FFFF;
    @(negedge clk);
    chk("cfg in reset", cwo, 0);
    chk("answer in reset", tv, 0);
    chk("time in reset", tim, 0);
    rst_n = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    chk("reload", cwo, {8'h00, FLASH_CODE, 12'h000, 4'h5, 4'h0});
    chk("reload pulse", cld, 1);
    tally_and_finish();
  end
  // watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
